// ---- hw/lcuf_lane_config_update_fsm.sv ----
// Purpose: Width reconfiguration substates of the link training machine:
//          configuration update and exit to detect.
// Assumes: All inputs but reset_in are synchronous to clk_in; the lane logic reports
//          bursts and sent idle ordered sets on its per-lane inputs.
// Notes:   Confirm wins over the timeout when both fall in one cycle.
//
// Summary of operation
// R1: On update entry all lanes are hibernating.
// R2: Update entry clears the recovery origin flag.
// R3: Lanes go to stall after hibernate dwell.
// R4: Confirm after activate dwell from all negative states.
// R5: Otherwise leave for exit after 2 ms.
// R6: Burst lanes send idle set, end burst; all configured lanes stall.
// R7: Then all configured lanes start hibernate entry.
// R8: Then reset every physical module of link.
// R9: After the exit steps, go to detect.
// R10: Timeout counter restarts on each update entry.
`timescale 1ns/10ps
module lcuf_lane_config_update_fsm #(
	parameter int TIMEOUT_CYCLES = lcuf_pkg::UPDATE_TIMEOUT_CYCLES
) (
	input  wire logic                        clk_in,
	input  wire logic                        reset_in,
	input  wire logic                        enter_update_in,
	input  wire logic                        recovery_set_in,
	input  wire logic [lcuf_pkg::LANES-1:0]  configured_lanes_in,
	input  wire logic [lcuf_pkg::LANES-1:0]  new_width_lanes_in,
	input  wire logic [lcuf_pkg::LANES-1:0]  rx_negative_differential_line_state_in,
	input  wire logic [lcuf_pkg::LANES-1:0]  tx_in_burst_in,
	input  wire logic [lcuf_pkg::LANES-1:0]  electrical_idle_ordered_set_sent_in,
	output lcuf_pkg::lcuf_lane_ctrl_type     lane_ctrl_out,
	output lcuf_pkg::lcuf_state_type         state_out,
	output logic                             recovery_origin_flag_out,
	output logic                             phy_reset_out,
	output logic                             go_confirm_out,
	output logic                             go_detect_out
);
	import lcuf_pkg::*;

	// The timeout and the dwell counters share one width. The default
	// timeout of 40000 cycles fits in sixteen bits with room to spare.
	// A faster core clock needs a wider timer, or the cut below would
	// silently shorten the timeout. Keep TIMEOUT_CYCLES above the sum
	// of both dwell counts. Otherwise a healthy remote port
	// can never reach confirm, and every update ends in exit.

	// Counts cut to the timer width once, so the compares stay clean.
	localparam logic [TIMER_WIDTH-1:0] TIMEOUT_LAST =
		TIMER_WIDTH'(TIMEOUT_CYCLES - 1);
	localparam logic [TIMER_WIDTH-1:0] HIBERNATE_LAST =
		TIMER_WIDTH'(HIBERNATE_DWELL_CYCLES - 1);
	localparam logic [TIMER_WIDTH-1:0] ACTIVATE_LAST =
		TIMER_WIDTH'(ACTIVATE_DWELL_CYCLES - 1);
	localparam logic [TIMER_WIDTH-1:0] TIMER_ZERO = '0;
	localparam logic [TIMER_WIDTH-1:0] TIMER_ONE  = TIMER_WIDTH'(1);

	lcuf_regs_type    regs;          // Registered state of the module.
	lcuf_regs_type    next_regs;     // Next value of the whole state.
	logic [LANES-1:0] electrical_idle_ordered_set_owed;     // Lanes that still owe an idle set.
	logic [LANES-1:0] electrical_idle_ordered_set_seen;     // Idle sets seen so far, this cycle too.
	logic             negative_differential_line_state_all;     // Every new width lane shows negative.

	// Per-lane bookkeeping for the idle ordered set step.
	for (genvar lane = 0; lane < LANES; lane++) begin : g_lane
		// A lane owes a set only if configured and bursting.
		assign electrical_idle_ordered_set_owed[lane] = configured_lanes_in[lane] &
			tx_in_burst_in[lane];
		// A sent set counts in the cycle it is reported.
		assign electrical_idle_ordered_set_seen[lane] = regs.electrical_idle_ordered_set_done[lane] | electrical_idle_ordered_set_sent_in[lane];
	end

	// Only lanes of the new width take part in the negative state check.
	assign negative_differential_line_state_all = ((rx_negative_differential_line_state_in & new_width_lanes_in) ==
		new_width_lanes_in);

	// The update state walks three phases: hibernate dwell, wait for
	// the negative line state on the new width, then activate dwell.
	// The exit path walks three states, the first until all owed sets are sent, so the order of
	// idle set, burst end, hibernate entry and local reset is fixed.
	// Hibernate entry is only requested here; its completion is not
	// awaited before the local reset, which the lane logic must allow.
	// A lane that loses the negative state during the activate dwell
	// is not noticed; the dwell runs from the first full detection.
	// Next state logic for the whole machine.
	always_comb begin
		next_regs = regs;
		// Pulses last a single cycle unless renewed below.
		next_regs.go_confirm = 1'b0;
		next_regs.go_detect  = 1'b0;
		next_regs.phy_reset  = 1'b0;
		next_regs.lanes.hibernate_request = LANES_ZERO;
		// An outside recovery event raises the flag, except in the cycle of update entry.
		if (recovery_set_in) begin
			next_regs.recovery_origin_flag = 1'b1;
		end
		case (regs.state)
			LCUF_DETECT, LCUF_CONFIRM: begin
				// Idle until the training logic enters the update state.
				if (enter_update_in) begin
					next_regs.state = LCUF_UPDATE;
					next_regs.phase = LCUF_PH_HIBERNATE;
					// Entry clears the flag, even over a same-cycle set.
					next_regs.recovery_origin_flag = 1'b0; // R2
					// Each entry gets a whole timeout interval.
					next_regs.timeout_count = TIMER_ZERO; // R10
					next_regs.dwell_count = TIMER_ZERO;
					// All lanes sit in deep hibernate on entry.
					next_regs.lanes.lane_stall = LANES_ZERO; // R1
				end
			end
			LCUF_UPDATE: begin
				// The timeout runs from entry in every phase.
				next_regs.timeout_count = regs.timeout_count + TIMER_ONE;
				next_regs.dwell_count = regs.dwell_count + TIMER_ONE;
				case (regs.phase)
					LCUF_PH_HIBERNATE: begin
						// Configured lanes leave hibernate after the dwell.
						if (regs.dwell_count == HIBERNATE_LAST) begin
							next_regs.lanes.lane_stall =
								configured_lanes_in; // R3
							next_regs.phase = LCUF_PH_WAIT_NEGATIVE_DIFFERENTIAL_LINE_STATE;
						end
					end
					LCUF_PH_WAIT_NEGATIVE_DIFFERENTIAL_LINE_STATE: begin
						// Activate dwell is measured from this detection.
						next_regs.dwell_count = TIMER_ZERO;
						if (negative_differential_line_state_all) begin
							next_regs.phase = LCUF_PH_ACTIVATE; // R4
						end
					end
					LCUF_PH_ACTIVATE: begin
						// Stall long enough on every configured lane: confirm.
						if (regs.dwell_count == ACTIVATE_LAST) begin
							next_regs.state = LCUF_CONFIRM; // R4
							next_regs.go_confirm = 1'b1;
						end
					end
					default: begin
						next_regs.phase = LCUF_PH_HIBERNATE;
					end
				endcase
				// Timeout only applies if confirm did not happen now.
				if (regs.timeout_count == TIMEOUT_LAST &&
					next_regs.state == LCUF_UPDATE) begin
					next_regs.state = LCUF_EXIT_BURST; // R5
					next_regs.electrical_idle_ordered_set_done = LANES_ZERO;
					next_regs.lanes.send_electrical_idle_ordered_set = electrical_idle_ordered_set_owed; // R6
				end
				// Counter is cleared on any exit from the state.
				if (next_regs.state != LCUF_UPDATE) begin
					next_regs.timeout_count = TIMER_ZERO; // R10
					next_regs.dwell_count = TIMER_ZERO;
				end
			end
			LCUF_EXIT_BURST: begin
				// Collect sets; a lane stops requesting once it has sent.
				next_regs.electrical_idle_ordered_set_done = electrical_idle_ordered_set_seen;
				next_regs.lanes.send_electrical_idle_ordered_set = regs.lanes.send_electrical_idle_ordered_set &
					~electrical_idle_ordered_set_sent_in;
				if ((electrical_idle_ordered_set_seen & regs.lanes.send_electrical_idle_ordered_set) ==
					regs.lanes.send_electrical_idle_ordered_set) begin
					// End the bursts and park every configured lane in stall.
					next_regs.lanes.end_burst = regs.lanes.send_electrical_idle_ordered_set |
						regs.electrical_idle_ordered_set_done; // R6
					next_regs.lanes.lane_stall = regs.lanes.lane_stall |
						configured_lanes_in; // R6
					next_regs.lanes.send_electrical_idle_ordered_set = LANES_ZERO;
					next_regs.state = LCUF_EXIT_HIBERNATE;
				end
			end
			LCUF_EXIT_HIBERNATE: begin
				// Bursts are over; begin hibernate entry on every configured lane.
				next_regs.lanes.end_burst = LANES_ZERO;
				next_regs.lanes.hibernate_request =
					configured_lanes_in; // R7
				next_regs.lanes.lane_stall = LANES_ZERO;
				next_regs.state = LCUF_EXIT_RESET;
			end
			LCUF_EXIT_RESET: begin
				// Local reset strictly after hibernate initiation.
				next_regs.phy_reset = 1'b1; // R8
				next_regs.go_detect = 1'b1; // R9
				next_regs.electrical_idle_ordered_set_done = LANES_ZERO;
				next_regs.state = LCUF_DETECT; // R9
			end
			default: begin
				next_regs.state = LCUF_DETECT;
			end
		endcase
	end

	// The reset is asynchronous so that the lanes leave any burst or
	// stall request at once, even without a running core clock.
	// Every field is listed, rather than loading a whole struct, so a
	// new field left out of reset is easy to spot. Release must still
	// be synchronous to the clock outside this block.
	// State register; reset loads constants only.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			regs.state <= LCUF_DETECT;
			regs.phase <= LCUF_PH_HIBERNATE;
			regs.timeout_count <= TIMER_ZERO;
			regs.dwell_count <= TIMER_ZERO;
			regs.electrical_idle_ordered_set_done <= LANES_ZERO;
			regs.recovery_origin_flag <= 1'b0;
			regs.phy_reset <= 1'b0;
			regs.go_confirm <= 1'b0;
			regs.go_detect <= 1'b0;
			regs.lanes <= '0;
		end else begin
			regs <= next_regs;
		end
	end

	// Pulses on these outputs last exactly one cycle. A consumer that
	// runs on a slower enable must stretch them itself, since nothing
	// here holds them until seen. Levels stay until the state moves.
	// All outputs come straight from flip-flops.
	assign lane_ctrl_out            = regs.lanes;
	assign state_out                = regs.state;
	assign recovery_origin_flag_out = regs.recovery_origin_flag;
	assign phy_reset_out            = regs.phy_reset;
	assign go_confirm_out           = regs.go_confirm;
	assign go_detect_out            = regs.go_detect;

endmodule

// ---- hw/lcuf_pkg.sv ----
// Purpose: Shared constants and types for the lane configuration update FSM.
// Assumes: One core clock at 20 MHz and a fixed count of lanes.
// Notes:   Timing figures are kept in their own units; the cycle counts are
//          derived from them and from the clock rate.
package lcuf_pkg;

	// Core clock rate in MHz and the number of lanes handled.
	localparam int CLK_MHZ     = 20;
	localparam int LANES       = 4;
	localparam int TIMER_WIDTH = 16;

	// Dwell times in ns; plain defaults, to be set by the integrator.
	localparam int HIBERNATE_DWELL_NS = 1000;
	localparam int ACTIVATE_DWELL_NS  = 1000;
	// Configuration update timeout in microseconds (2 ms).
	localparam int UPDATE_TIMEOUT_US  = 2000;

	// Least times round up to whole cycles, and never below one cycle.
	localparam int HIBERNATE_DWELL_RAW = (HIBERNATE_DWELL_NS * CLK_MHZ + 999) / 1000;
	localparam int ACTIVATE_DWELL_RAW  = (ACTIVATE_DWELL_NS * CLK_MHZ + 999) / 1000;
	localparam int HIBERNATE_DWELL_CYCLES =
		(HIBERNATE_DWELL_RAW < 1) ? 1 : HIBERNATE_DWELL_RAW;
	localparam int ACTIVATE_DWELL_CYCLES =
		(ACTIVATE_DWELL_RAW < 1) ? 1 : ACTIVATE_DWELL_RAW;
	// The timeout is exact in whole cycles at this rate.
	localparam int UPDATE_TIMEOUT_CYCLES = UPDATE_TIMEOUT_US * CLK_MHZ;

	// Reset values of the lane outputs and flags.
	localparam logic [LANES-1:0] LANES_ZERO = '0;

	// Top level states of the substate machine.
	typedef enum logic [2:0] {
		LCUF_DETECT,
		LCUF_UPDATE,
		LCUF_CONFIRM,
		LCUF_EXIT_BURST,
		LCUF_EXIT_HIBERNATE,
		LCUF_EXIT_RESET
	} lcuf_state_type;

	// Phases inside the configuration update state.
	typedef enum logic [1:0] {
		LCUF_PH_HIBERNATE,
		LCUF_PH_WAIT_NEGATIVE_DIFFERENTIAL_LINE_STATE,
		LCUF_PH_ACTIVATE
	} lcuf_phase_type;

	// Lane control outputs that travel together.
	typedef struct packed {
		logic [LANES-1:0] lane_stall;
		logic [LANES-1:0] send_electrical_idle_ordered_set;
		logic [LANES-1:0] end_burst;
		logic [LANES-1:0] hibernate_request;
	} lcuf_lane_ctrl_type;

	// Whole state of the module.
	typedef struct packed {
		lcuf_state_type     state;
		lcuf_phase_type     phase;
		logic [TIMER_WIDTH-1:0] timeout_count;
		logic [TIMER_WIDTH-1:0] dwell_count;
		logic [LANES-1:0]   electrical_idle_ordered_set_done;
		logic               recovery_origin_flag;
		logic               phy_reset;
		logic               go_confirm;
		logic               go_detect;
		lcuf_lane_ctrl_type lanes;
	} lcuf_regs_type;

endpackage

// ---- verif/lcuf_fsm_checker.sv ----
// Purpose: Port checks of the width update and exit substates.
// Assumes: One clock domain; dwell counts are the package's 20 cycles.
// Notes:   Entry of a state is seen as a change of state_out.
`timescale 1ns/10ps
module lcuf_fsm_checker #(
	parameter int TIMEOUT_CYCLES = lcuf_pkg::UPDATE_TIMEOUT_CYCLES
) (
	input wire logic                  clk_in,
	input wire logic                  reset_in,
	input wire logic [3:0]            configured_lanes_in,
	input wire logic [3:0]            new_width_lanes_in,
	input wire logic [3:0]            rx_negative_differential_line_state_in,
	input wire logic [3:0]            tx_in_burst_in,
	input lcuf_pkg::lcuf_lane_ctrl_type lane_ctrl_out,
	input lcuf_pkg::lcuf_state_type   state_out,
	input wire logic                  recovery_origin_flag_out,
	input wire logic                  phy_reset_out,
	input wire logic                  go_confirm_out,
	input wire logic                  go_detect_out
);
	import lcuf_pkg::*;
	int upd_count; // Cycles spent in update since its entry.
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// Any other state clears the count, so each entry starts afresh.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			upd_count <= 0;
		else
			upd_count <= (state_out == LCUF_UPDATE) ? upd_count + 1 : 0;
	end
	property p_entry;
		state_out == LCUF_UPDATE && $past(state_out) != LCUF_UPDATE |->
			lane_ctrl_out.lane_stall == 4'h0 && !recovery_origin_flag_out;
	endproperty
	a_entry: assert property (p_entry) else $error("entry");
	property p_stall;
		state_out == LCUF_UPDATE && lane_ctrl_out.lane_stall != 4'h0 &&
			$past(lane_ctrl_out.lane_stall) == 4'h0 |->
			$past(state_out, 20) == LCUF_UPDATE &&
			$past(state_out, 21) != LCUF_UPDATE;
	endproperty
	a_stall: assert property (p_stall) else $error("stall");
	property p_confirm;
		go_confirm_out |-> state_out == LCUF_CONFIRM &&
			$past((rx_negative_differential_line_state_in & new_width_lanes_in) == new_width_lanes_in, 20);
	endproperty
	a_confirm: assert property (p_confirm) else $error("confirm");
	property p_timeout;
		state_out == LCUF_EXIT_BURST && $past(state_out) == LCUF_UPDATE
			|-> upd_count == TIMEOUT_CYCLES;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout");
	property p_inupd;
		state_out == LCUF_UPDATE |-> upd_count < TIMEOUT_CYCLES;
	endproperty
	a_inupd: assert property (p_inupd) else $error("residency");
	property p_burst;
		state_out == LCUF_EXIT_HIBERNATE |->
			$past(state_out) == LCUF_EXIT_BURST &&
			lane_ctrl_out.end_burst == $past(configured_lanes_in & tx_in_burst_in)
			&& (lane_ctrl_out.lane_stall & configured_lanes_in) ==
			configured_lanes_in;
	endproperty
	a_burst: assert property (p_burst) else $error("burst end");
	property p_hib;
		state_out == LCUF_EXIT_RESET |-> $past(state_out) ==
			LCUF_EXIT_HIBERNATE && lane_ctrl_out.lane_stall == 4'h0 &&
			lane_ctrl_out.hibernate_request == configured_lanes_in;
	endproperty
	a_hib: assert property (p_hib) else $error("hibernate");
	property p_detect;
		state_out == LCUF_EXIT_RESET |=>
			phy_reset_out && go_detect_out && state_out == LCUF_DETECT;
	endproperty
	a_detect: assert property (p_detect) else $error("detect");
endmodule
bind lcuf_lane_config_update_fsm lcuf_fsm_checker #(
	.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) lcuf_fsm_checker_inst (.*);

// ---- verif/lcuf_remote_port.sv ----
// Purpose: Remote port model that drives our receive lane line states.
// Assumes: It follows our stall lanes; respond_in low mutes it.
// Notes:   A muted port never shows the negative state, so we time out.
`timescale 1ns/10ps
module lcuf_remote_port #(
	parameter int DELAY = 3
) (
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	input  wire logic       respond_in,
	input  wire logic [3:0] stall_in,
	input  wire logic [3:0] width_in,
	output logic      [3:0] negative_differential_line_state_out
);
	int wait_count; // Cycles our lanes have stalled.
	// Count stall residency; the wait restarts only when no lane stalls.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in || stall_in == 4'h0)
			wait_count <= 0;
		else
			wait_count <= wait_count + 1;
	end
	// Late answer on the new width lanes only, never on the others.
	assign negative_differential_line_state_out = (respond_in && wait_count > DELAY) ? width_in : 4'h0;
endmodule

// ---- verif/lcuf_lane_config_update_fsm_tb.sv ----
// Purpose: Self-checking bench for the width update substates.
// Assumes: Update timeout shortened to 50 cycles for run time.
// Notes:   Inputs move and outputs are read on the falling edge.
`timescale 1ns/10ps
module lcuf_lane_config_update_fsm_tb;
	import lcuf_pkg::*;
	localparam int TO = 50; // Shortened update timeout in cycles.
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic enter_update_in = 1'b0;
	logic recovery_set_in = 1'b0;
	logic respond = 1'b1; // The remote port answers when set.
	logic [3:0] configured_lanes_in = 4'hF;
	logic [3:0] new_width_lanes_in = 4'h3;
	logic [3:0] tx_in_burst_in = 4'h5;
	logic [3:0] electrical_idle_ordered_set_sent_in = 4'h0;
	logic [3:0] rx_negative_differential_line_state_in;
	lcuf_lane_ctrl_type lane_ctrl_out;
	lcuf_state_type state_out;
	logic recovery_origin_flag_out, phy_reset_out;
	logic go_confirm_out, go_detect_out;
	int n_mismatch = 0;
	int samples_checked = 0;
	int n;
	always #25 clk_in = ~clk_in; // 20 MHz core clock.
	lcuf_lane_config_update_fsm #(.TIMEOUT_CYCLES(TO))
		lcuf_lane_config_update_fsm_inst (.*);
	lcuf_remote_port lcuf_remote_port_inst (.clk_in(clk_in),
		.reset_in(reset_in), .respond_in(respond),
		.stall_in(lane_ctrl_out.lane_stall),
		.width_in(new_width_lanes_in), .negative_differential_line_state_out(rx_negative_differential_line_state_in));
	// Compare one value and count it.
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Bounded wait, so a stuck machine fails its check instead of hanging.
	task automatic wait_state(input lcuf_state_type s);
		n = 0;
		do begin
			@(negedge clk_in);
			n++;
		end while (state_out !== s && n < 200);
	endtask
	// Raise the origin flag, enter update and confirm the new width.
	task automatic t_confirm;
		recovery_set_in = 1'b1;
		@(negedge clk_in);
		recovery_set_in = 1'b0;
		enter_update_in = 1'b1;
		check(16'(recovery_origin_flag_out), 16'h1);
		@(negedge clk_in);
		enter_update_in = 1'b0;
		check(16'(state_out), 16'(LCUF_UPDATE));
		check(16'(recovery_origin_flag_out), 16'h0);
		check(16'(lane_ctrl_out.lane_stall), 16'h0);
		wait_state(LCUF_CONFIRM);
		check(16'(go_confirm_out), 16'h1);
		check(16'(n > HIBERNATE_DWELL_CYCLES + ACTIVATE_DWELL_CYCLES), 16'h1);
		check(16'(lane_ctrl_out.lane_stall), 16'hF);
		$display("test confirm done");
	endtask
	// Re-enter with a mute remote port and the request held high.
	task automatic t_timeout;
		respond = 1'b0;
		enter_update_in = 1'b1;
		wait_state(LCUF_EXIT_BURST);
		enter_update_in = 1'b0;
		check(16'(n), 16'(TO + 1));
		check(16'(lane_ctrl_out.send_electrical_idle_ordered_set), 16'h5);
		@(negedge clk_in);
		check(16'(state_out), 16'(LCUF_EXIT_BURST));
		electrical_idle_ordered_set_sent_in = lane_ctrl_out.send_electrical_idle_ordered_set;
		@(negedge clk_in);
		electrical_idle_ordered_set_sent_in = 4'h0;
		check(16'(state_out), 16'(LCUF_EXIT_HIBERNATE));
		check(16'(lane_ctrl_out.end_burst), 16'h5);
		check(16'(lane_ctrl_out.lane_stall), 16'hF);
		@(negedge clk_in);
		check(16'(lane_ctrl_out.hibernate_request), 16'hF);
		@(negedge clk_in);
		check(16'({phy_reset_out, go_detect_out}), 16'h3);
		check(16'(state_out), 16'(LCUF_DETECT));
		$display("test timeout done");
	endtask
	// Main sequence: reset for five cycles, then the scenarios.
	initial begin
		repeat (5) @(negedge clk_in);
		reset_in = 1'b0;
		check(16'(state_out), 16'(LCUF_DETECT));
		t_confirm;
		t_timeout;
		end_of_test;
	end
	// The run needs some 110 cycles; 2000 cycles means a hang.
	initial begin
		#100000;
		n_mismatch++;
		end_of_test;
	end
endmodule
